// ### shared/adc_seq_params.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_SEL 8'h04
`define OFS_RES_LO 8'h08
`define OFS_RES_HI 8'h0C
`define OFS_STATUS 8'h10
// ----------------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------------
`define CTRL_EN 0
`define CTRL_START 1
`define CTRL_AUTO 2
`define CTRL_DONE 3
`define CTRL_FREE 4
`define CTRL_DIV_LO 5
`define CTRL_DIV_HI 7
// ----------------------------------------------------------------------------
// Reset values, first differential channel and timing, in half converter clock cycles except the trigger sync count in reference clock cycles
// ----------------------------------------------------------------------------
`define SEL_RESET 7'h00
`define DIV_RESET 3'h0
`define DIFF_FIRST 5'h08
`define SH_NORM 6'h03
`define DONE_NORM 6'h1A
`define SH_EXT 6'h1B
`define DONE_EXT 6'h32
`define SH_TRIG 6'h04
`define DONE_TRIG 6'h1B
`define SYNC_SLIP 6'h02
`define TRIG_SYNC_CYC 2'h3
`endif

// ### shared/adc_seq_pkg.sv
// Types shared by the conversion sequencer and its bench
package adc_seq_pkg;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
    typedef struct packed {
        logic enable;
        logic busy;
        logic sample_hold;
        logic conv_clk;
        logic [4:0] channel_select_bits;
        logic [1:0] reference_select_bits;
    } analog_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_SYNC = 4'b0100,
        ST_CONV = 4'b1000
    } seq_state_t;
endpackage

// ### logic/adc_conversion_sequencer.sv
// Conversion sequencer: prescaler, timing, selection buffer, APB registers
`include "adc_seq_params.svh"
module adc_conversion_sequencer (
    input wire logic REF_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CE_IN,
    input wire adc_seq_pkg::apb_req_t APB_REQ_IN,
    output adc_seq_pkg::apb_rsp_t APB_RSP_OUT,
    input wire logic TRIGGER_IN,
    input wire logic [9:0] RESULT_IN,
    output adc_seq_pkg::analog_t ANALOG_OUT
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        adc_seq_pkg::seq_state_t fsm;
        logic [6:0] presc;
        logic ck2;
        logic [5:0] hcnt;
        logic [5:0] sh_at;
        logic [5:0] done_at;
        logic [1:0] sync;
        logic first;
        logic en;
        logic start;
        logic auto_en;
        logic free_src;
        logic done;
        logic [2:0] divsel;
        logic [6:0] tmp_sel;
        logic [6:0] act_sel;
        logic [9:0] result;
        logic lock;
        logic trig_prev;
        adc_seq_pkg::apb_rsp_t rsp;
        adc_seq_pkg::analog_t ana;
    } seq_regs_t;

    seq_regs_t st_q, st_d;
    logic rst_meta_q, rst_sync_q;
    logic [6:0] last;
    logic rise, htick, trig_edge, diff, access, complete;
    logic [31:0] rd;

    // Last prescaler count for the chosen power-of-two ratio
    function automatic logic [6:0] div_last(input logic [2:0] s);
        if (s == 3'h0) return 7'h01;
        return 7'((8'h01 << s) - 8'h01);
    endfunction

    // Sample-hold and completion points in half converter cycles
    function automatic logic [11:0] conv_time(input logic ext,
                                              input logic trig,
                                              input logic slow);
        if (ext) return {`SH_EXT, `DONE_EXT};
        if (trig) return {`SH_TRIG, `DONE_TRIG};
        if (slow) return {`SH_NORM + `SYNC_SLIP, `DONE_NORM + `SYNC_SLIP};
        return {`SH_NORM, `DONE_NORM};
    endfunction

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Two-stage release of the asynchronous reset
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Tick decode shared by the sequencer and the checks
    assign last = div_last(st_q.divsel);
    assign rise = st_q.en && (st_q.presc >= last); // Wraps after a ratio cut
    assign htick = rise || (st_q.en && (st_q.presc == (last >> 1)));
    assign trig_edge = TRIGGER_IN && !st_q.trig_prev;
    assign diff = st_q.act_sel[4:0] >= `DIFF_FIRST;
    assign access = APB_REQ_IN.psel && APB_REQ_IN.penable;
    assign complete = (st_q.fsm == adc_seq_pkg::ST_CONV) && htick &&
                      ({1'b0, st_q.hcnt} + 7'h01 == {1'b0, st_q.done_at});

    // Sequencer, prescaler and register file
    always_comb begin
        st_d = st_q;
        rd = 32'h0000_0000;
        st_d.rsp.pready = 1'b0;
        st_d.ana.sample_hold = 1'b0;
        st_d.trig_prev = TRIGGER_IN;
        // Prescaler free runs only while enabled
        if (!st_q.en || rise) begin
            st_d.presc = 7'h00;
        end else begin
            st_d.presc = st_q.presc + 7'h01;
        end
        if (!st_q.en) begin
            st_d.ck2 = 1'b0;
        end else if (rise) begin
            st_d.ck2 = !st_q.ck2;
        end
        // Read mux
        case (APB_REQ_IN.paddr)
            `OFS_CTRL: rd = {24'h0, st_q.divsel, st_q.free_src, st_q.done,
                             st_q.auto_en, st_q.start, st_q.en};
            `OFS_SEL: rd = {17'h0, st_q.act_sel, 1'b0, st_q.tmp_sel};
            `OFS_RES_LO: rd = {24'h0, st_q.result[7:0]};
            `OFS_RES_HI: rd = {30'h0, st_q.result[9:8]};
            `OFS_STATUS: rd = {28'h0, st_q.first, st_q.lock, st_q.ck2,
                               st_q.fsm == adc_seq_pkg::ST_CONV};
            default: rd = 32'h0000_0000;
        endcase
        // APB: one wait state, effects at the completing edge
        if (access && !st_q.rsp.pready) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.prdata = rd;
            st_d.rsp.pslverr = !(APB_REQ_IN.paddr inside {`OFS_CTRL,
                `OFS_SEL, `OFS_RES_LO, `OFS_RES_HI, `OFS_STATUS});
        end
        if (access && st_q.rsp.pready && APB_REQ_IN.pwrite) begin
            case (APB_REQ_IN.paddr)
                `OFS_CTRL: begin
                    st_d.en = APB_REQ_IN.pwdata[`CTRL_EN];
                    st_d.auto_en = APB_REQ_IN.pwdata[`CTRL_AUTO];
                    st_d.free_src = APB_REQ_IN.pwdata[`CTRL_FREE];
                    st_d.divsel = APB_REQ_IN.pwdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
                    if (APB_REQ_IN.pwdata[`CTRL_DONE]) st_d.done = 1'b0;
                    if (APB_REQ_IN.pwdata[`CTRL_START] && st_q.en &&
                        st_q.fsm == adc_seq_pkg::ST_IDLE) begin
                        st_d.start = 1'b1;
                        st_d.fsm = adc_seq_pkg::ST_WAIT;
                    end
                end
                `OFS_SEL: st_d.tmp_sel = APB_REQ_IN.pwdata[6:0];
                default: st_d.tmp_sel = st_q.tmp_sel;
            endcase
        end
        if (access && st_q.rsp.pready && !APB_REQ_IN.pwrite) begin
            if (APB_REQ_IN.paddr == `OFS_RES_LO) st_d.lock = 1'b1;
            if (APB_REQ_IN.paddr == `OFS_RES_HI) st_d.lock = 1'b0;
        end
        // Conversion sequence
        case (st_q.fsm)
            adc_seq_pkg::ST_IDLE: begin
                // Trigger edge while idle; busy edges fall through
                if (st_q.en && st_q.auto_en && !st_q.free_src &&
                    trig_edge) begin
                    st_d.fsm = adc_seq_pkg::ST_SYNC;
                    st_d.sync = `TRIG_SYNC_CYC - 2'h1;
                    st_d.start = 1'b1;
                end
            end
            adc_seq_pkg::ST_WAIT: begin
                if (rise) begin
                    st_d.fsm = adc_seq_pkg::ST_CONV;
                    st_d.hcnt = 6'h00;
                    st_d.first = 1'b0;
                    {st_d.sh_at, st_d.done_at} = conv_time(st_q.first, 1'b0,
                        diff && st_q.ck2);
                end
            end
            adc_seq_pkg::ST_SYNC: begin
                if (st_q.sync == 2'h0) begin
                    st_d.presc = 7'h00;
                    st_d.ck2 = 1'b0;
                    st_d.fsm = adc_seq_pkg::ST_CONV;
                    st_d.hcnt = 6'h00;
                    st_d.first = 1'b0;
                    {st_d.sh_at, st_d.done_at} = conv_time(st_q.first ||
                        diff, 1'b1, 1'b0);
                end else begin
                    st_d.sync = st_q.sync - 2'h1;
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (htick) begin
                    st_d.hcnt = st_q.hcnt + 6'h01;
                    if (st_q.hcnt + 6'h01 == st_q.sh_at) begin
                        st_d.ana.sample_hold = 1'b1;
                    end
                end
                if (complete) begin
                    st_d.done = 1'b1;
                    if (!st_q.lock) st_d.result = RESULT_IN;
                    st_d.hcnt = 6'h00;
                    if (st_q.auto_en && st_q.free_src) begin
                        {st_d.sh_at, st_d.done_at} = conv_time(1'b0, 1'b0,
                            diff);
                    end else begin
                        st_d.fsm = adc_seq_pkg::ST_IDLE;
                        st_d.start = 1'b0;
                    end
                end
            end
            default: st_d.fsm = adc_seq_pkg::ST_IDLE;
        endcase
        // Active selection follows the buffer except mid-conversion
        if (st_q.fsm != adc_seq_pkg::ST_CONV ||
            {1'b0, st_q.hcnt} + 7'h02 >= {1'b0, st_q.done_at}) begin
            st_d.act_sel = st_q.tmp_sel;
        end
        // Disabled converter aborts and arms the extended conversion
        if (!st_q.en) begin
            st_d.fsm = adc_seq_pkg::ST_IDLE;
            st_d.start = 1'b0;
            st_d.first = 1'b1;
            st_d.hcnt = 6'h00;
        end
        // Front-end outputs, all registered
        st_d.ana.enable = st_d.en;
        st_d.ana.busy = st_d.fsm == adc_seq_pkg::ST_CONV;
        st_d.ana.conv_clk = st_d.en && (st_d.presc > (last >> 1));
        st_d.ana.channel_select_bits = st_d.act_sel[4:0];
        st_d.ana.reference_select_bits = st_d.act_sel[6:5];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Clock enable freezes everything
    always_ff @(posedge REF_CLK_IN or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            st_q <= '0;
            st_q.fsm <= adc_seq_pkg::ST_IDLE;
            st_q.first <= 1'b1;
            st_q.tmp_sel <= `SEL_RESET;
            st_q.act_sel <= `SEL_RESET;
            st_q.divsel <= `DIV_RESET;
        end else if (CE_IN) begin
            st_q <= st_d;
        end
    end

    assign APB_RSP_OUT = st_q.rsp;
    assign ANALOG_OUT = st_q.ana;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Sync cycles that really advance, and the conversion entry point
    sequence s_sync_run;
        (CE_IN && st_q.en) [*3];
    endsequence
    sequence s_enter_conv;
        st_q.fsm == adc_seq_pkg::ST_CONV && st_q.hcnt == 6'h00;
    endsequence

    a_presc_held: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && !st_q.en |=> st_q.presc == 7'h00)
        else $error("prescaler ran while disabled");
    a_start_on_rise: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.fsm == adc_seq_pkg::ST_WAIT &&
        st_q.en && rise |=> s_enter_conv)
        else $error("start missed prescaled edge");
    a_normal_len: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.fsm == adc_seq_pkg::ST_WAIT &&
        st_q.en && rise && !st_q.first && !diff |=> st_q.done_at == 6'h1A)
        else $error("normal conversion length wrong");
    a_first_len: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.fsm == adc_seq_pkg::ST_WAIT &&
        st_q.en && rise && st_q.first |=> st_q.done_at == 6'h32 &&
        st_q.sh_at == 6'h1B)
        else $error("first conversion length wrong");
    a_sh_point: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) $rose(st_q.ana.sample_hold) |->
        st_q.hcnt == st_q.sh_at && st_q.fsm == adc_seq_pkg::ST_CONV)
        else $error("sample-hold off its point");
    a_done_clears: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.en && complete &&
        !(st_q.auto_en && st_q.free_src) |=> st_q.done && !st_q.start)
        else $error("completion bookkeeping wrong");
    a_trig_sync: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) $rose(st_q.fsm == adc_seq_pkg::ST_SYNC) ##0
        s_sync_run |-> (st_q.fsm == adc_seq_pkg::ST_SYNC) ##1
        (s_enter_conv and (st_q.presc == 7'h00)))
        else $error("trigger sync wrong");
    a_free_run: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.en && complete &&
        st_q.auto_en && st_q.free_src |=> (s_enter_conv and st_q.start))
        else $error("free running restart lost");
    a_diff_slow: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.fsm == adc_seq_pkg::ST_WAIT &&
        st_q.en && rise && !st_q.first && diff && st_q.ck2
        |=> st_q.done_at == 6'h1C)
        else $error("differential slip missing");
    a_sel_frozen: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) st_q.fsm == adc_seq_pkg::ST_CONV &&
        st_q.hcnt > 6'h00 && {1'b0, st_q.hcnt} + 7'h02 < {1'b0, st_q.done_at}
        |-> $stable(st_q.act_sel))
        else $error("selection moved mid-conversion");
    a_lock_hold: assert property (@(posedge REF_CLK_IN)
        disable iff (!rst_sync_q) CE_IN && st_q.lock && complete &&
        !(access && st_q.rsp.pready) |=> $stable(st_q.result) && st_q.done)
        else $error("locked result overwritten");
endmodule // adc_conversion_sequencer

// ### test/adc_sar_model.sv
// Behavioural successive-approximation core beside the sequencer
module adc_sar_model (
    input wire logic clk_in,
    input wire adc_seq_pkg::analog_t analog_in,
    output logic [9:0] result_out,
    output logic [9:0] held_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] tally_q = 5'h00;
    logic [9:0] held_q = 10'h000;
    // Capture channel and a running tally at each sample strobe
    always @(posedge clk_in) begin
        if (analog_in.sample_hold === 1'b1) begin
            tally_q <= tally_q + 5'h01;
            held_q <= {analog_in.channel_select_bits, tally_q};
        end
    end
    // Result only while busy; inverse otherwise so stale reads show
    assign result_out = (analog_in.busy === 1'b1) ? held_q : ~held_q;
    assign held_out = held_q;
endmodule // adc_sar_model

// ### test/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`include "adc_seq_params.svh"
module adc_conversion_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Signals, clock, design and core model
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic trig = 1'b0;
    logic ce = 1'b1;
    adc_seq_pkg::apb_req_t req = '0;
    adc_seq_pkg::apb_rsp_t rsp;
    adc_seq_pkg::analog_t ana;
    logic [9:0] res;
    logic [9:0] held;
    logic [31:0] rv;
    logic busy_p = 1'b0;
    logic trig_p = 1'b0;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0, t_rise = 0, t_fall = 0, t_sh = 0, t_shp = 0;
    int t_trig = 0, n_sh = 0;
    always #25 clk = ~clk;
    adc_conversion_sequencer dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
        .CE_IN(ce), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
        .TRIGGER_IN(trig), .RESULT_IN(res), .ANALOG_OUT(ana));
    adc_sar_model sar (.clk_in(clk), .analog_in(ana), .result_out(res),
        .held_out(held));
    // Cycle stamps of busy edges, strobes and trigger rises
    always @(posedge clk) begin
        cyc <= cyc + 1;
        busy_p <= ana.busy;
        trig_p <= trig;
        if (ana.busy === 1'b1 && busy_p === 1'b0) begin
            t_rise <= cyc;
        end
        if (ana.busy === 1'b0 && busy_p === 1'b1) begin
            t_fall <= cyc;
        end
        if (ana.sample_hold === 1'b1) begin
            t_shp <= t_sh;
            t_sh <= cyc;
            n_sh <= n_sh + 1;
        end
        if (trig === 1'b1 && trig_p === 1'b0) begin
            t_trig <= cyc;
        end
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        chk("pready wait", {31'h0, rsp.pready}, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, rv, e);
    endtask
    task automatic rd(input logic [7:0] a);
        logic e;
        apb(1'b0, a, 32'h0, rv, e);
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] dv,
        input logic [4:0] b);
        return {24'h0, dv, b};
    endfunction
    task automatic wait_busy(input logic lv);
        int n;
        n = 0;
        while (ana.busy !== lv && n < 3000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk("busy wait", {31'h0, ana.busy}, {31'h0, lv});
    endtask
    task automatic pulse_trig();
        @(posedge clk);
        trig <= 1'b1;
        wait_busy(1'b1);
        trig <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic e;
        rd(`OFS_CTRL);
        chk("ctrl reset", rv, 32'h0);
        rd(`OFS_STATUS);
        chk("status reset", rv, 32'h8);
        apb(1'b0, 8'h14, 32'h0, rv, e);
        chk("unmapped", {31'h0, e}, 32'h1);
    endtask
    task automatic t_first();
        wr(`OFS_CTRL, ctl(3'h2, 5'h02));
        repeat (4) @(posedge clk);
        chk("start while off", {31'h0, ana.busy}, 32'h0);
        wr(`OFS_SEL, 32'h25);
        wr(`OFS_CTRL, ctl(3'h2, 5'h01));
        wr(`OFS_CTRL, ctl(3'h2, 5'h03));
        wait_busy(1'b1);
        repeat (8) @(posedge clk);
        wr(`OFS_SEL, 32'h03);
        rd(`OFS_CTRL);
        chk("start while busy", rv & 32'h2, 32'h2);
        chk("held sel", {25'h0, ana.reference_select_bits,
            ana.channel_select_bits}, 32'h25);
        wait_busy(1'b0);
        chk("first length", t_fall - t_rise, 100);
        chk("first sample", t_sh - t_rise, 54);
        rd(`OFS_CTRL);
        chk("done no start", rv & 32'hA, 32'h8);
        rd(`OFS_SEL);
        chk("sel reload", {25'h0, rv[14:8]}, 32'h3);
        rd(`OFS_RES_LO);
        chk("result low", rv, {24'h0, held[7:0]});
        rd(`OFS_RES_HI);
        chk("result high", rv, {30'h0, held[9:8]});
    endtask
    task automatic t_div();
        // Fast ratios keep runs short; resolution is not modelled
        for (int d = 1; d < 4; d++) begin
            wr(`OFS_CTRL, ctl(3'(d), 5'h0B));
            wait_busy(1'b1);
            wait_busy(1'b0);
            chk("normal length", t_fall - t_rise, 13 << d);
            chk("normal sample", t_sh - t_rise, 3 << (d - 1));
        end
    endtask
    task automatic t_lock();
        logic [31:0] lo;
        rd(`OFS_RES_LO);
        lo = rv;
        wr(`OFS_CTRL, ctl(3'h1, 5'h0B));
        wait_busy(1'b1);
        wait_busy(1'b0);
        rd(`OFS_CTRL);
        chk("done when locked", rv & 32'h8, 32'h8);
        rd(`OFS_RES_HI);
        rd(`OFS_RES_LO);
        chk("locked low", rv, lo);
        rd(`OFS_RES_HI);
    endtask
    task automatic t_auto();
        int tt;
        int n0;
        wr(`OFS_CTRL, ctl(3'h0, 5'h0D));
        n0 = n_sh;
        pulse_trig();
        tt = t_trig;
        repeat (4) @(posedge clk);
        trig <= 1'b1;
        wait_busy(1'b0);
        trig <= 1'b0;
        repeat (20) @(posedge clk);
        // Strobe is seen one cycle after its registered point
        chk("trigger sample", t_sh - tt, 8);
        chk("trigger length", t_fall - t_rise, 27);
        chk("edge ignored", n_sh - n0, 1);
        chk("no restart", {31'h0, ana.busy}, 32'h0);
    endtask
    task automatic t_abort();
        wr(`OFS_CTRL, ctl(3'h0, 5'h0B));
        wait_busy(1'b1);
        wr(`OFS_CTRL, ctl(3'h0, 5'h00));
        repeat (2) @(posedge clk);
        chk("abort idle", {31'h0, ana.busy}, 32'h0);
        chk("abort outputs", {30'h0, ana.enable, ana.conv_clk}, 32'h0);
        wr(`OFS_CTRL, ctl(3'h0, 5'h01));
        wr(`OFS_CTRL, ctl(3'h0, 5'h0B));
        wait_busy(1'b1);
        // Ten frozen cycles stretch the conversion
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        wait_busy(1'b0);
        chk("rearmed length", t_fall - t_rise, 60);
    endtask
    task automatic t_diff();
        wr(`OFS_SEL, 32'h08);
        for (int i = 0; i < 2; i++) begin
            wr(`OFS_CTRL, ctl(3'h0, 5'h00));
            wr(`OFS_CTRL, ctl(3'h0, 5'h0D));
            pulse_trig();
            wait_busy(1'b0);
            chk("diff auto length", t_fall - t_rise, 50);
        end
    endtask
    task automatic t_free();
        int n0;
        int n;
        wr(`OFS_CTRL, ctl(3'h0, 5'h1F));
        wait_busy(1'b1);
        n0 = n_sh;
        n = 0;
        while (n_sh < n0 + 3 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        chk("free interval", t_sh - t_shp, 28);
        rd(`OFS_CTRL);
        chk("start kept", rv & 32'h2, 32'h2);
        wr(`OFS_CTRL, ctl(3'h0, 5'h00));
    endtask
    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_first();
        t_div();
        t_lock();
        t_auto();
        t_abort();
        t_diff();
        t_free();
        end_of_test();
    end
    initial begin
        #(50 * 40000);
        error_cnt++;
        end_of_test();
    end
endmodule // adc_conversion_sequencer_test
